// ==== core/nal_map.vh ====
// Constants for the network address loader: timing, addresses, EEPROM image layout.
// Assumes a 25 MHz system clock and a 100 kHz I2C bus on the EEPROM bus.
`ifndef NAL_MAP_VH
`define NAL_MAP_VH
`define NAL_CLK_MHZ 25
`define NAL_QTR_NS 2500
`define NAL_QTR_CYC ((`NAL_QTR_NS * `NAL_CLK_MHZ + 999) / 1000)
`define NAL_DIV_W 6
`define NAL_EEP_DEV 7'h50
`define NAL_CTRL_DEV 7'h60
`define NAL_STAT_DEV 7'h61
`define NAL_AUTO_BYTES 5'h10
`define NAL_MAC_OFS 4'h0
`define NAL_IP_OFS 4'h6
`define NAL_MODE_OFS 4'ha
`define NAL_MAGIC_OFS 4'hb
`define NAL_MAGIC 8'ha5
`define NAL_MODE_HW_ID_ONLY 2'h0
`define NAL_MODE_FULL_NETWORK_LOAD 2'h1
`define NAL_CTRL_FLAGS 4'ha
`endif

// ==== core/nal_loader.v ====
// Network address loader: two I2C masters on the EEPROM bus, two I2C slaves on the
// management bus, and the selection of the MAC and IP address handed to IPbus.
// Assumes open-drain pins resolved outside; user_* inputs are on clk_i.
`timescale 1ns/1ns
`include "nal_map.vh"

module nal_i2c_master (
  input wire clk_i,
  input wire rst_i,
  input wire go_i,
  input wire wr_i,
  input wire [6:0] dev_i,
  input wire [7:0] reg_i,
  input wire [7:0] wdata_i,
  input wire [4:0] nbytes_i,
  input wire sda_i,
  output reg scl_oe_o,
  output reg sda_oe_o,
  output reg busy_o,
  output reg byte_stb_o,
  output reg [7:0] byte_o,
  output reg done_o,
  output reg err_o
);
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_TX = 3'd2;
  localparam S_RX = 3'd3;
  localparam S_STOP = 3'd4;
  reg [2:0] st;
  reg [1:0] q;
  reg [`NAL_DIV_W-1:0] div;
  reg [3:0] b;
  reg [1:0] seq;
  reg [8:0] sh;
  reg [4:0] left;
  reg wr;
  reg nack;
  wire tick = (div == `NAL_QTR_CYC - 1);
  always @(posedge clk_i) begin
    byte_stb_o <= 1'b0;
    done_o <= 1'b0;
    if (rst_i) begin
      st <= S_IDLE;
      q <= 2'h0;
      div <= {`NAL_DIV_W{1'b0}};
      b <= 4'h0;
      seq <= 2'h0;
      sh <= 9'h000;
      left <= 5'h00;
      wr <= 1'b0;
      nack <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      busy_o <= 1'b0;
      byte_o <= 8'h00;
      err_o <= 1'b0;
    end else if (st == S_IDLE) begin
      div <= {`NAL_DIV_W{1'b0}};
      q <= 2'h0;
      if (go_i) begin
        busy_o <= 1'b1;
        err_o <= 1'b0;
        nack <= 1'b0;
        wr <= wr_i;
        left <= nbytes_i;
        seq <= 2'h0;
        st <= S_START;
      end
    end else begin
      div <= tick ? {`NAL_DIV_W{1'b0}} : div + {{(`NAL_DIV_W-1){1'b0}}, 1'b1};
      if (tick) begin
        q <= q + 2'h1;
        case (st)
          S_START: begin
            case (q)
              2'h0: sda_oe_o <= 1'b0;
              2'h1: scl_oe_o <= 1'b0;
              2'h2: sda_oe_o <= 1'b1;
              default: begin
                scl_oe_o <= 1'b1;
                b <= 4'h0;
                st <= S_TX;
                sh <= {dev_i, seq == 2'h3, 1'b1};
              end
            endcase
          end
          S_TX: begin
            case (q)
              2'h0: sda_oe_o <= ~sh[8];
              2'h1: scl_oe_o <= 1'b0;
              2'h2: if (b == 4'h8) nack <= sda_i;
              default: begin
                scl_oe_o <= 1'b1;
                sh <= {sh[7:0], 1'b1};
                b <= b + 4'h1;
                if (b == 4'h8) begin
                  b <= 4'h0;
                  if (nack) begin
                    err_o <= 1'b1;
                    st <= S_STOP;
                  end else begin
                    case (seq)
                      2'h0: begin
                        seq <= 2'h1;
                        sh <= {reg_i, 1'b1};
                      end
                      2'h1: begin
                        if (wr) begin
                          seq <= 2'h2;
                          sh <= {wdata_i, 1'b1};
                        end else begin
                          seq <= 2'h3;
                          st <= S_START;
                        end
                      end
                      2'h2: st <= S_STOP;
                      default: st <= S_RX;
                    endcase
                  end
                end
              end
            endcase
          end
          S_RX: begin
            case (q)
              2'h0: sda_oe_o <= (b == 4'h8) && (left != 5'h01);
              2'h1: scl_oe_o <= 1'b0;
              2'h2: if (b != 4'h8) sh <= {sh[7:0], sda_i};
              default: begin
                scl_oe_o <= 1'b1;
                b <= b + 4'h1;
                if (b == 4'h8) begin
                  b <= 4'h0;
                  byte_stb_o <= 1'b1;
                  byte_o <= sh[7:0];
                  left <= left - 5'h01;
                  if (left == 5'h01) st <= S_STOP;
                end
              end
            endcase
          end
          S_STOP: begin
            case (q)
              2'h0: sda_oe_o <= 1'b1;
              2'h1: scl_oe_o <= 1'b0;
              2'h2: sda_oe_o <= 1'b0;
              default: begin
                st <= S_IDLE;
                busy_o <= 1'b0;
                done_o <= 1'b1;
              end
            endcase
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end
endmodule // nal_i2c_master

module nal_i2c_slave #(
  parameter [6:0] DEV = 7'h00
) (
  input wire clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  input wire [7:0] rd_data_i,
  output reg sda_oe_o,
  output reg wr_stb_o,
  output reg [3:0] wr_idx_o,
  output reg [7:0] wr_data_o,
  output reg [3:0] rd_idx_o
);
  localparam T_IDLE = 3'd0;
  localparam T_ADDR = 3'd1;
  localparam T_ACK = 3'd2;
  localparam T_WR = 3'd3;
  localparam T_RD = 3'd4;
  localparam T_RACK = 3'd5;
  reg [2:0] st;
  reg [3:0] cnt;
  reg [7:0] sh;
  reg rw;
  reg first;
  reg scl_q;
  reg sda_q;
  wire rise = scl_i & ~scl_q;
  wire fall = ~scl_i & scl_q;
  wire start = scl_i & scl_q & sda_q & ~sda_i;
  wire stop = scl_i & scl_q & ~sda_q & sda_i;
  always @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    wr_stb_o <= 1'b0;
    if (rst_i) begin
      st <= T_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_idx_o <= 4'h0;
      wr_data_o <= 8'h00;
      rd_idx_o <= 4'h0;
    end else if (start) begin
      st <= T_ADDR;
      cnt <= 4'h0;
      first <= 1'b1;
      sda_oe_o <= 1'b0;
    end else if (stop) begin
      st <= T_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (st)
        T_ADDR, T_WR: begin
          if (rise) begin
            sh <= {sh[6:0], sda_i};
            cnt <= cnt + 4'h1;
          end
          if (fall && cnt == 4'h8) begin
            sda_oe_o <= 1'b1;
            st <= T_ACK;
            if (st == T_ADDR) begin
              rw <= sh[0];
              if (sh[7:1] != DEV) begin
                sda_oe_o <= 1'b0;
                st <= T_IDLE;
              end
            end else if (first) begin
              first <= 1'b0;
              rd_idx_o <= sh[3:0];
            end else begin
              wr_stb_o <= 1'b1;
              wr_idx_o <= rd_idx_o;
              wr_data_o <= sh;
              rd_idx_o <= rd_idx_o + 4'h1;
            end
          end
        end
        T_ACK: begin
          if (fall) begin
            cnt <= 4'h0;
            if (rw) begin
              sh <= rd_data_i;
              sda_oe_o <= ~rd_data_i[7];
              st <= T_RD;
            end else begin
              sda_oe_o <= 1'b0;
              st <= T_WR;
            end
          end
        end
        T_RD: begin
          if (fall) begin
            cnt <= cnt + 4'h1;
            sh <= {sh[6:0], 1'b0};
            sda_oe_o <= ~sh[6];
            if (cnt == 4'h7) begin
              sda_oe_o <= 1'b0;
              rd_idx_o <= rd_idx_o + 4'h1;
              st <= T_RACK;
            end
          end
        end
        // Master ack: the next byte is loaded at the fall that ends the ack bit
        T_RACK: if (rise) st <= sda_i ? T_IDLE : T_ACK;
        default: st <= T_IDLE;
      endcase
    end
  end
endmodule // nal_i2c_slave

module nal_loader (
  input wire clk_i,
  input wire rst_i,
  input wire eep_scl_i,
  input wire eep_sda_i,
  output reg eep_scl_o,
  output reg eep_scl_oe_o,
  output reg eep_sda_o,
  output reg eep_sda_oe_o,
  input wire mmc_scl_i,
  input wire mmc_sda_i,
  output reg mmc_sda_o,
  output reg mmc_sda_oe_o,
  input wire [31:0] user_ip_i,
  input wire [47:0] user_mac_i,
  input wire ipb_go_i,
  input wire ipb_wr_i,
  input wire [6:0] ipb_dev_i,
  input wire [7:0] ipb_reg_i,
  input wire [7:0] ipb_wdata_i,
  output reg ipb_busy_o,
  output reg ipb_done_o,
  output reg ipb_err_o,
  output reg [7:0] ipb_rdata_o,
  output reg [31:0] ip_o,
  output reg [47:0] mac_o,
  output reg rarp_o,
  output reg cfg_done_o,
  output reg eep_valid_o
);
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [7:0] eep [0:15];
  reg [7:0] ctrl [0:15];
  reg [3:0] eep_idx;
  reg auto_fired;
  reg auto_go;
  reg auto_ok;
  reg ip_ovr;
  reg mac_ovr;
  integer i;
  wire a_scl;
  wire a_sda;
  wire a_stb;
  wire [7:0] a_byte;
  wire a_done;
  wire a_err;
  wire o_scl;
  wire o_sda;
  wire o_busy;
  wire o_stb;
  wire [7:0] o_byte;
  wire o_done;
  wire o_err;
  wire c_oe;
  wire c_stb;
  wire [3:0] c_widx;
  wire [7:0] c_wdata;
  wire [3:0] c_ridx;
  wire s_oe;
  wire [3:0] s_ridx;
  wire [1:0] mode = eep[`NAL_MODE_OFS][1:0];
  wire valid = auto_ok && (eep[`NAL_MAGIC_OFS] == `NAL_MAGIC);
  wire [31:0] eep_ip = {eep[6], eep[7], eep[8], eep[9]};
  wire [47:0] eep_mac = {eep[0], eep[1], eep[2], eep[3], eep[4], eep[5]};
  wire [31:0] ctrl_ip = {ctrl[6], ctrl[7], ctrl[8], ctrl[9]};
  wire [47:0] ctrl_mac = {ctrl[0], ctrl[1], ctrl[2], ctrl[3], ctrl[4], ctrl[5]};
  wire [7:0] flags = {eep_valid_o, cfg_done_o, ip_ovr, mac_ovr, 2'h0, mode};
  wire [127:0] stat_vec = {mac_o, ip_o, flags, 40'h00_0000_0000};
  wire [7:0] stat_rd = stat_vec[(8'd127 - {1'b0, s_ridx, 3'h0}) -: 8];
  wire [31:0] next_ip = ip_ovr ? ctrl_ip :
    (valid && mode == `NAL_MODE_FULL_NETWORK_LOAD) ? eep_ip : user_ip_i;
  wire [47:0] next_mac = mac_ovr ? ctrl_mac : valid ? eep_mac : user_mac_i;

  nal_i2c_master u_auto (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(auto_go), .wr_i(1'b0),
    .dev_i(`NAL_EEP_DEV), .reg_i(8'h00), .wdata_i(8'h00),
    .nbytes_i(`NAL_AUTO_BYTES), .sda_i(sync2[0]),
    .scl_oe_o(a_scl), .sda_oe_o(a_sda), .busy_o(),
    .byte_stb_o(a_stb), .byte_o(a_byte), .done_o(a_done), .err_o(a_err)
  );

  nal_i2c_master u_ondemand (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(ipb_go_i & cfg_done_o & ~o_busy),
    .wr_i(ipb_wr_i), .dev_i(ipb_dev_i), .reg_i(ipb_reg_i), .wdata_i(ipb_wdata_i),
    .nbytes_i(5'h01), .sda_i(sync2[0]),
    .scl_oe_o(o_scl), .sda_oe_o(o_sda), .busy_o(o_busy),
    .byte_stb_o(o_stb), .byte_o(o_byte), .done_o(o_done), .err_o(o_err)
  );

  nal_i2c_slave #(.DEV(`NAL_CTRL_DEV)) u_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(sync2[2]), .sda_i(sync2[1]),
    .rd_data_i(ctrl[c_ridx]), .sda_oe_o(c_oe), .wr_stb_o(c_stb),
    .wr_idx_o(c_widx), .wr_data_o(c_wdata), .rd_idx_o(c_ridx)
  );

  nal_i2c_slave #(.DEV(`NAL_STAT_DEV)) u_stat (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(sync2[2]), .sda_i(sync2[1]),
    .rd_data_i(stat_rd), .sda_oe_o(s_oe), .wr_stb_o(), .wr_idx_o(),
    .wr_data_o(), .rd_idx_o(s_ridx)
  );

  always @(posedge clk_i) begin
    sync1 <= {mmc_scl_i, mmc_sda_i, eep_sda_i};
    sync2 <= sync1;
    auto_go <= 1'b0;
    ipb_done_o <= o_done;
    if (rst_i) begin
      auto_fired <= 1'b0;
      auto_ok <= 1'b0;
      eep_idx <= 4'h0;
      ip_ovr <= 1'b0;
      mac_ovr <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        eep[i] <= 8'h00;
        ctrl[i] <= 8'h00;
      end
      eep_scl_o <= 1'b0;
      eep_scl_oe_o <= 1'b0;
      eep_sda_o <= 1'b0;
      eep_sda_oe_o <= 1'b0;
      mmc_sda_o <= 1'b0;
      mmc_sda_oe_o <= 1'b0;
      ipb_busy_o <= 1'b1;
      ipb_err_o <= 1'b0;
      ipb_rdata_o <= 8'h00;
      ip_o <= 32'h0000_0000;
      mac_o <= 48'h0000_0000_0000;
      rarp_o <= 1'b0;
      cfg_done_o <= 1'b0;
      eep_valid_o <= 1'b0;
    end else begin
      if (!auto_fired) begin
        auto_fired <= 1'b1;
        auto_go <= 1'b1;
      end
      if (a_stb) begin
        eep[eep_idx] <= a_byte;
        eep_idx <= eep_idx + 4'h1;
      end
      if (a_done) begin
        cfg_done_o <= 1'b1;
        auto_ok <= ~a_err;
      end
      if (c_stb) begin
        ctrl[c_widx] <= c_wdata;
        if (c_widx == `NAL_CTRL_FLAGS) begin
          ip_ovr <= c_wdata[0];
          mac_ovr <= c_wdata[1];
        end else if (c_widx >= `NAL_IP_OFS && c_widx < `NAL_MODE_OFS) begin
          ip_ovr <= 1'b1;
        end else if (c_widx < `NAL_IP_OFS) begin
          mac_ovr <= 1'b1;
        end
      end
      eep_scl_oe_o <= a_scl | o_scl;
      eep_sda_oe_o <= a_sda | o_sda;
      mmc_sda_oe_o <= c_oe | s_oe;
      ipb_busy_o <= o_busy | ~cfg_done_o;
      if (o_done) ipb_err_o <= o_err;
      if (o_stb) ipb_rdata_o <= o_byte;
      eep_valid_o <= valid;
      if (cfg_done_o) begin
        ip_o <= next_ip;
        mac_o <= next_mac;
        rarp_o <= (next_ip == 32'h0000_0000);
      end
    end
  end
endmodule // nal_loader

// ==== tb/nal_loader_assertions.sv ====
// Checker for the network address loader: reset, start-up and selection relations.
// Bound to nal_loader; sees only its ports, single clock domain.
`timescale 1ns/1ns
module nal_loader_chk (
  input wire clk_i,
  input wire rst_i,
  input wire eep_scl_oe_o,
  input wire eep_sda_oe_o,
  input wire [31:0] user_ip_i,
  input wire [47:0] user_mac_i,
  input wire ipb_go_i,
  input wire ipb_busy_o,
  input wire ipb_done_o,
  input wire [31:0] ip_o,
  input wire [47:0] mac_o,
  input wire rarp_o,
  input wire cfg_done_o,
  input wire eep_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_idle4;
    (cfg_done_o && !ipb_busy_o && !ipb_go_i) [*4];
  endsequence
  sequence s_sel_user;
    eep_valid_o || (ip_o == user_ip_i && mac_o == user_mac_i);
  endsequence
  a_reset_vals: assert property (
    $fell(rst_i) |-> ipb_busy_o && !cfg_done_o && ip_o == 32'h0000_0000)
    else $error("outputs not cleared by reset");
  a_cfg_stays: assert property (
    cfg_done_o |=> cfg_done_o)
    else $error("auto-read finished flag dropped");
  a_bus_quiet: assert property (
    s_idle4 |-> !eep_scl_oe_o && !eep_sda_oe_o)
    else $error("EEPROM bus driven while idle");
  a_busy_early: assert property (
    !cfg_done_o |-> ipb_busy_o)
    else $error("on-demand master free before auto-read end");
  a_rarp_zero: assert property (
    $past(cfg_done_o) && $stable(ip_o) |-> rarp_o == (ip_o == 32'h0000_0000))
    else $error("address request flag wrong");
  a_fallback: assert property (
    $rose(cfg_done_o) |-> ##[0:2] s_sel_user)
    else $error("invalid image did not select user address");
  a_done_pulse: assert property (
    ipb_done_o |=> !ipb_done_o)
    else $error("done longer than one cycle");
  a_go_busy: assert property (
    ipb_go_i && !ipb_busy_o |-> ##[1:2] ipb_busy_o)
    else $error("on-demand request not taken");
endmodule // nal_loader_chk

bind nal_loader nal_loader_chk i_chk (.*);

// ==== tb/nal_eep_model.sv ====
// Behavioural serial EEPROM at device address 0x50: pointer write, byte write, sequential read.
// Open-drain: sda_pull_o high pulls the data line low; pull-ups assumed.
`timescale 1ns/1ns
module nal_eep_model (
  input wire scl_i,
  input wire sda_i,
  input wire nak_i,
  output reg sda_pull_o
);
  reg [7:0] mem [0:15];
  reg [7:0] sh = 8'h00;
  reg [3:0] ptr = 4'h0;
  integer cnt = 0;
  integer nb = 0;
  reg act = 1'b0;
  reg rd = 1'b0;
  reg mnak = 1'b0;
  initial sda_pull_o = 1'b0;
  // Start and stop are recognised only with the clock line high
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    act = 1'b1;
    rd = 1'b0;
    cnt = 0;
    nb = 0;
    mnak = 1'b0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) act = 1'b0;
  always @(posedge scl_i) if (act) begin
    if (rd && nb > 0) begin
      if (cnt == 8) mnak = sda_i;
    end else sh = {sh[6:0], sda_i};
    cnt = cnt + 1;
  end
  always @(negedge scl_i) if (act) begin
    if (cnt == 8) begin
      sda_pull_o = 1'b0;
      if (nb == 0) begin
        rd = sh[0];
        sda_pull_o = !nak_i && sh[7:1] == 7'h50;
        act = sda_pull_o;
      end else if (!rd) begin
        if (nb == 1) ptr = sh[3:0];
        else begin
          mem[ptr] = sh;
          ptr = ptr + 4'h1;
        end
        sda_pull_o = 1'b1;
      end
    end else if (cnt == 9) begin
      if (rd && nb > 0) ptr = ptr + 4'h1;
      nb = nb + 1;
      cnt = 0;
      sda_pull_o = rd && !mnak && !mem[ptr][7];
      if (rd && mnak) act = 1'b0;
    end else if (rd && nb > 0) sda_pull_o = !mem[ptr][7 - cnt];
  end
endmodule // nal_eep_model

// ==== tb/tb_network_address_loader.sv ====
// Testbench for the network address loader: auto-read, on-demand write, management slaves.
// Uses nal_eep_model on the EEPROM bus; the bench itself is the management master.
`timescale 1ns/1ns
module tb_network_address_loader;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg nak = 1'b1;
  reg mscl = 1'b1;
  reg msda = 1'b1;
  reg [31:0] user_ip_i = 32'h0000_0000;
  reg [47:0] user_mac_i = 48'h0000_0000_0000;
  reg go = 1'b0;
  reg [7:0] wreg = 8'h00;
  reg [7:0] wdat = 8'h00;
  wire scl_oe, sda_oe, pull, msda_oe, busy, done, err, rarp, cfg, valid;
  wire [31:0] ip;
  wire [47:0] mac;
  wire eep_scl = !scl_oe;
  wire eep_sda = !(sda_oe | pull);
  // No bridge between the buses: management and EEPROM buses never join
  wire mmc_sda = msda & !msda_oe;
  integer n_fail = 0;
  integer checked = 0;
  integer cyc = 0;
  integer k, j, seed;
  reg acc;
  reg [79:0] got;
  reg [47:0] emac;
  reg [31:0] v;
  reg [8:0] r;
  reg [7:0] img [0:15];
  always #20 clk_i = !clk_i;
  nal_loader i_dut (.clk_i(clk_i), .rst_i(rst_i), .eep_scl_i(eep_scl), .eep_sda_i(eep_sda),
    .eep_scl_o(), .eep_scl_oe_o(scl_oe), .eep_sda_o(), .eep_sda_oe_o(sda_oe),
    .mmc_scl_i(mscl), .mmc_sda_i(mmc_sda), .mmc_sda_o(), .mmc_sda_oe_o(msda_oe),
    .user_ip_i(user_ip_i), .user_mac_i(user_mac_i), .ipb_go_i(go), .ipb_wr_i(1'b1),
    .ipb_dev_i(7'h50), .ipb_reg_i(wreg), .ipb_wdata_i(wdat), .ipb_busy_o(busy),
    .ipb_done_o(done), .ipb_err_o(err), .ipb_rdata_o(), .ip_o(ip), .mac_o(mac),
    .rarp_o(rarp), .cfg_done_o(cfg), .eep_valid_o(valid));
  nal_eep_model i_eep (.scl_i(eep_scl), .sda_i(eep_sda), .nak_i(nak), .sda_pull_o(pull));
  task summarize;
    begin
      if (n_fail == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [79:0] g, input [79:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("BAD %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task do_reset;
    begin
      @(posedge clk_i) rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      while (cfg !== 1'b1) @(negedge clk_i);
      repeat (3) @(negedge clk_i);
    end
  endtask
  task ms(input c, input d);
    begin
      @(posedge clk_i);
      mscl <= c;
      msda <= d;
      repeat (5) @(posedge clk_i);
    end
  endtask
  task mstart;
    begin
      ms(1'b0, 1'b1);
      ms(1'b1, 1'b1);
      ms(1'b1, 1'b0);
      ms(1'b0, 1'b0);
    end
  endtask
  task mstop;
    begin
      ms(1'b0, 1'b0);
      ms(1'b1, 1'b0);
      ms(1'b1, 1'b1);
    end
  endtask
  task mbyte(input [8:0] d, output [8:0] q);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        ms(1'b0, d[i]);
        ms(1'b1, d[i]);
        @(negedge clk_i) q[i] = mmc_sda;
        ms(1'b0, d[i]);
      end
    end
  endtask
  task mw(input [7:0] b);
    begin
      mbyte({b, 1'b1}, r);
      acc = acc | r[0];
    end
  endtask
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 115000) begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  initial begin
    seed = $urandom(75);
    v = $urandom;
    user_ip_i <= $urandom;
    user_mac_i <= {v[15:0], $urandom};
    for (k = 0; k < 16; k = k + 1) img[k] = $urandom;
    img[10] = 8'h01;
    img[11] = 8'ha5;
    for (k = 0; k < 16; k = k + 1) i_eep.mem[k] = img[k];
    do_reset;
    chk(valid, 1'b0);
    chk(ip, user_ip_i);
    chk(mac, user_mac_i);
    nak <= 1'b0;
    do_reset;
    emac = {img[0], img[1], img[2], img[3], img[4], img[5]};
    chk(valid, 1'b1);
    chk(ip, {img[6], img[7], img[8], img[9]});
    chk(mac, emac);
    v = $urandom;
    @(posedge clk_i);
    wreg <= {4'h0, v[3:0]};
    wdat <= v[15:8];
    go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    while (done !== 1'b1) @(negedge clk_i);
    chk(err, 1'b0);
    chk(i_eep.mem[v[3:0]], v[15:8]);
    for (k = 0; k < 2; k = k + 1) begin
      v = (k == 0) ? $urandom : 32'h0000_0000;
      acc = 1'b0;
      mstart;
      mw(8'hc0);
      mw(8'h06);
      for (j = 3; j >= 0; j = j - 1) mw(v[8 * j +: 8]);
      mstop;
      repeat (4) @(negedge clk_i);
      chk(ip, v);
      chk(rarp, v == 32'h0000_0000);
      mstart;
      mw(8'hc2);
      mw(8'h00);
      mstart;
      mw(8'hc3);
      for (j = 9; j >= 0; j = j - 1) begin
        mbyte({8'hff, j == 0}, r);
        got[8 * j +: 8] = r[8:1];
      end
      mstop;
      chk(acc, 1'b0);
      chk(got, {emac, v});
    end
    img[10] = 8'h00;
    for (k = 0; k < 16; k = k + 1) i_eep.mem[k] = img[k];
    do_reset;
    chk(valid, 1'b1);
    chk(ip, user_ip_i);
    chk(mac, emac);
    summarize;
  end
endmodule // tb_network_address_loader
